/* File: bench/qcel_fsm_properties.sv */
// Purpose: Timing checks on the queue state machine ports.
// Assumes: Latencies as handed over: command frame two edges on, read setup one.
// Notes: Bound into every qcel_queue_fsm instance.
`timescale 1ns/10ps
module qcel_fsm_props #(
  parameter int SLOTS = 32
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Requests and configuration.
  input wire logic cmd_valid,
  input wire qcel_pkg::qcel_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic phase_valid,
  input wire logic phase_is_write,
  input wire logic [4:0] phase_slot,
  input wire logic phase_ready,
  input wire logic auto_act_supported,
  input wire logic auto_act_enabled,
  // Answers.
  input wire logic frame_valid,
  input wire qcel_pkg::qcel_frame_t frame,
  input wire logic log_done,
  input wire logic halted,
  input wire logic [SLOTS-1:0] outstanding
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Accepted requests and the auto-activate choice.
  wire logic take_c = cmd_valid && cmd_ready;
  wire logic take_p = phase_valid && phase_ready;
  wire logic aa = auto_act_supported && auto_act_enabled;
  halt_blocks_cmd_a: assert property (halted |-> !cmd_ready)
    else $error("command accepted while halted");
  log_clears_queue_a: assert property (log_done |-> ##[0:1] (outstanding == '0 && !halted))
    else $error("queue not cleared by log read");
  enqueue_slot_a: assert property (take_c && !cmd.malformed |-> ##2 outstanding[$past(cmd.slot, 2)])
    else $error("slot not stored");
  malformed_path_a: assert property (take_c && cmd.malformed |-> ##2 frame_valid && frame.irq)
    else $error("malformed command not refused");
  release_frame_a: assert property (take_c && !cmd.malformed |-> ##2 frame_valid && !frame.irq
    && frame.kind == qcel_pkg::QCEL_FR_REG && !frame.status[7] && !frame.status[3])
    else $error("release frame wrong");
  read_setup_a: assert property (take_p && !phase_is_write |=> frame_valid && frame.dir_to_host
    && frame.kind == qcel_pkg::QCEL_FR_DMA_SETUP && frame.buf_id == $past(phase_slot))
    else $error("read setup frame wrong");
  write_auto_a: assert property (take_p && phase_is_write && aa |-> ##2 frame_valid
    && frame.auto_act && !frame.dir_to_host && frame.buf_id == $past(phase_slot, 2))
    else $error("auto write setup wrong");
  write_plain_a: assert property (take_p && phase_is_write && !aa |-> ##2 frame_valid && !frame.auto_act)
    else $error("plain write setup wrong");
  error_frame_a: assert property (frame_valid && frame.irq |-> frame.error == 8'h04
    && frame.status[0] && !frame.status[7] && !frame.status[3])
    else $error("error frame wrong");
  // Main scenarios reached.
  cover property (take_c && cmd.malformed);
  cover property (take_p && phase_is_write && aa);
  cover property (log_done);
endmodule : qcel_fsm_props
bind qcel_queue_fsm qcel_fsm_props #(.SLOTS(SLOTS)) props (.*);

/* File: bench/qcel_host_model.sv */
// Purpose: Transport side that answers frames and sinks log bytes.
// Assumes: One frame_done per frame, after a short or long delay.
// Notes: Slow mode also stalls the sink so the buffer fills.
`timescale 1ns/10ps
module qcel_host_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  // Frame handshake and pacing.
  input wire logic frame_valid,
  input wire logic slow,
  output logic frame_done,
  // Log byte sink.
  output logic log_ready
);
  logic [3:0] cnt;
  logic [2:0] pace;
  // The counter saturates, so a frame that stays up is never answered twice.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      pace <= 3'h0;
      frame_done <= 1'b0;
    end else begin
      pace <= pace + 3'h1;
      frame_done <= frame_valid && cnt == (slow ? 4'h6 : 4'h1);
      cnt <= !frame_valid ? 4'h0 : (cnt == 4'hf) ? cnt : cnt + 4'h1;
    end
  end
  // A slow sink takes one beat in four.
  assign log_ready = !slow || pace[1:0] == 2'h3;
endmodule : qcel_host_model

/* File: bench/testbench.sv */
// Purpose: Self-checking bench for the queue state machine.
// Assumes: The host model answers frames and paces the log sink.
// Notes: Checks frames, queue bits and the whole log page twice.
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst_b, clk_en, cmd_valid, cmd_ready, phase_valid, phase_is_write, phase_ready;
  logic auto_act_supported, auto_act_enabled, err_valid, log_read, frame_valid, frame_done, slow;
  logic log_valid, log_ready, log_done, halted, read_data_start, write_data_start;
  logic [4:0] phase_slot;
  logic [7:0] vendor_byte, log_page, log_data, sum, eb;
  logic [31:0] outstanding;
  qcel_pkg::qcel_cmd_t cmd;
  qcel_pkg::qcel_err_img_t err_img;
  qcel_pkg::qcel_frame_t frame, fr;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  qcel_queue_fsm uut (.*);
  qcel_host_model host (.*);
  // Free-running system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Report the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // A hang costs a mismatch and ends the run.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One command or phase request, held until taken; the frame is kept in fr.
  task automatic req(logic ph, logic w, logic [4:0] s, logic m);
    @(posedge clk_sys);
    cmd_valid <= !ph;
    phase_valid <= ph;
    cmd <= '{w, s, m};
    phase_is_write <= w;
    phase_slot <= s;
    @(posedge clk_sys);
    for (int k = 0; k < 40 && (ph ? phase_ready : cmd_ready) !== 1'b1; k++) @(posedge clk_sys);
    cmd_valid <= 1'b0;
    phase_valid <= 1'b0;
    for (int k = 0; k < 40 && frame_valid !== 1'b1; k++) @(posedge clk_sys);
    fr = frame;
    for (int k = 0; k < 40 && frame_valid !== 1'b0; k++) @(posedge clk_sys);
  endtask : req
  function automatic logic [7:0] exp_byte(int i);
    case (i)
      0: return {err_img.non_queued, 2'b00, err_img.non_queued ? 5'h00 : err_img.slot};
      2: return err_img.status;
      3: return err_img.error;
      4: return err_img.sect_num;
      5: return err_img.cyl_low;
      6: return err_img.cyl_high;
      7: return err_img.dev_head;
      8: return err_img.sect_num_exp;
      9: return err_img.cyl_low_exp;
      10: return err_img.cyl_high_exp;
      12: return err_img.sect_cnt;
      13: return err_img.sect_cnt_exp;
      default: return (i > 255) ? vendor_byte : 8'h00;
    endcase
  endfunction : exp_byte
  // Ask for a log page; a wrong page must stay silent, the error page streams whole.
  task automatic read_log(logic [7:0] pg);
    int k;
    @(posedge clk_sys);
    log_read <= 1'b1;
    log_page <= pg;
    @(posedge clk_sys);
    log_read <= 1'b0;
    if (pg != 8'h10) begin
      repeat (8) @(posedge clk_sys);
      chk("log_valid", log_valid, 1'b0);
      return;
    end
    sum = 8'h00;
    for (int i = 0; i < 512; i++) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (!(log_valid && log_ready) && k < 40);
      eb = (i == 511) ? 8'h00 - sum : exp_byte(i);
      chk("log byte", log_data, eb);
      sum = sum + eb;
    end
    repeat (3) @(posedge clk_sys);
    chk("idle", {halted, cmd_ready}, 2'h1);
    chk("queue clear", outstanding, 32'h0000_0000);
  endtask : read_log
  // Main sequence.
  initial begin
    {rst_b, cmd_valid, phase_valid, phase_is_write, phase_slot, err_valid} = '0;
    {log_read, log_page, slow, cmd, err_img, vendor_byte} = '0;
    {clk_en, auto_act_supported, auto_act_enabled} = 3'h7;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    chk("cmd_ready", cmd_ready, 1'b1);
    req(0, 0, 5'd3, 0);
    chk("release", {fr.kind, fr.status, fr.irq}, {qcel_pkg::QCEL_FR_REG, 8'h40, 1'b0});
    req(0, 1, 5'd31, 0);
    chk("queue", outstanding, 32'h8000_0008);
    req(1, 0, 5'd3, 0);
    chk("rd setup", {fr.kind, fr.buf_id, fr.dir_to_host}, {2'h1, 5'd3, 1'b1});
    chk("rd start", {read_data_start, write_data_start}, 2'h2);
    for (int a = 0; a < 3; a++) begin
      {auto_act_supported, auto_act_enabled} <= (a == 0) ? 2'h3 : (a == 1) ? 2'h2 : 2'h1;
      req(1, 1, 5'd31, 0);
      chk("wr setup", {fr.buf_id, fr.dir_to_host, fr.auto_act}, {5'd31, 1'b0, a == 0});
      chk("wr start", {read_data_start, write_data_start}, 2'h1);
    end
    req(0, 0, 5'd7, 1);
    chk("bad cmd", {fr.status, fr.error, fr.irq}, {8'h41, 8'h04, 1'b1});
    chk("halt", {halted, cmd_ready}, 2'h2);
    for (int t = 0; t < 2; t++) begin
      if (t == 1) req(0, 0, 5'd9, 0);
      @(posedge clk_sys);
      err_valid <= 1'b1;
      err_img <= '{t == 1, 5'd5, 8'h51, 8'h04, 8'h11, 8'h22, 8'h33, 8'he0, 8'h44, 8'h55,
                   8'h66, 8'h07, 8'h08};
      vendor_byte <= (t == 0) ? 8'ha5 : 8'h3c;
      slow <= (t == 0);
      @(posedge clk_sys);
      err_valid <= 1'b0;
      read_log(8'h20);
      read_log(8'h10);
    end
    tally_and_finish();
  end
endmodule : testbench

/* File: rtl/qcel_defs.svh */
// Purpose: Constants for the queued-command error log and queue state machine.
// Assumes: 100 MHz clk_sys; bytes of the log page leave one per accepted beat.
// Notes: Behaviour list below.
// Behaviour
// - Halt commands after error until log read
// - Log page read aborts queue, returns idle
// - Log page is 512 bytes, 0 to 511
// - Byte 0: non-queued flag bit 7, slot
// - Flag set for non-queued, clear when valid
// - Bytes 2..7 status, error, address image
// - Log error byte kept apart from shadow
// - Invalid slot reports abort bit only
// - Vendor bytes 256..510; reserved bytes zero
// - Byte 511 makes page sum zero
// - Enqueue stores slot; malformed goes error state
// - Release frame: busy, request, interrupt zero
// - Read setup: buffer slot, direction one
// - Auto-activate path only if supported, enabled
// - Auto setup: direction zero, auto-activate one
// - Malformed: halt, error frame, code 04
`ifndef QCEL_DEFS_SVH
`define QCEL_DEFS_SVH
`define QCEL_LOG_PAGE 8'h10
`define QCEL_LOG_LAST 9'h1ff
`define QCEL_VENDOR_FIRST 9'h100
`define QCEL_NQ_BIT 7
`define QCEL_ABORT_ERR 8'h04
`define QCEL_STAT_ERR 8'h01
`define QCEL_STAT_READY 8'h40
`endif

/* File: rtl/qcel_pkg.sv */
// Purpose: Types shared by the queue state machine and its bench checks.
// Assumes: Up to 32 queue slots.
// Notes: Constants live in qcel_defs.svh.
package qcel_pkg;
  // Kind of frame asked of the transport layer.
  typedef enum logic [1:0] {
    QCEL_FR_REG,
    QCEL_FR_DMA_SETUP
  } qcel_frame_kind_t;

  // A frame request to the transport layer.
  typedef struct packed {
    qcel_frame_kind_t kind;
    logic [7:0] status;
    logic [7:0] error;
    logic irq;
    logic [4:0] buf_id;
    logic dir_to_host;
    logic auto_act;
  } qcel_frame_t;

  // Failure image captured for the log page.
  typedef struct packed {
    logic non_queued;
    logic [4:0] slot;
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] sect_num;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] dev_head;
    logic [7:0] sect_num_exp;
    logic [7:0] cyl_low_exp;
    logic [7:0] cyl_high_exp;
    logic [7:0] sect_cnt;
    logic [7:0] sect_cnt_exp;
  } qcel_err_img_t;

  // Incoming queued command.
  typedef struct packed {
    logic is_write;
    logic [4:0] slot;
    logic malformed;
  } qcel_cmd_t;
endpackage : qcel_pkg

/* File: rtl/qcel_queue_fsm.sv */
// Purpose: Queued command entry, setup frames, error halt and error log page.
// Assumes: Transport signals frame_done once per requested frame.
// Notes: Later data, status and error states are handled elsewhere.
`timescale 1ns/10ps
`include "qcel_defs.svh"
module qcel_queue_fsm #(
  parameter int SLOTS = 32
) (
  // Clock, reset, enable.
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Command entry.
  input wire logic cmd_valid,
  input wire qcel_pkg::qcel_cmd_t cmd,
  output logic cmd_ready,
  // Data phase start for a queued slot.
  input wire logic phase_valid,
  input wire logic phase_is_write,
  input wire logic [4:0] phase_slot,
  output logic phase_ready,
  // Configuration.
  input wire logic auto_act_supported,
  input wire logic auto_act_enabled,
  // Error report from the rest of the device.
  input wire logic err_valid,
  input wire qcel_pkg::qcel_err_img_t err_img,
  input wire logic [7:0] vendor_byte,
  // Log page read request.
  input wire logic log_read,
  input wire logic [7:0] log_page,
  // Frame request to transport.
  output logic frame_valid,
  output qcel_pkg::qcel_frame_t frame,
  input wire logic frame_done,
  // Log page byte stream.
  output logic log_valid,
  output logic [7:0] log_data,
  input wire logic log_ready,
  output logic log_done,
  // State.
  output logic halted,
  output logic read_data_start,
  output logic write_data_start,
  output logic [SLOTS-1:0] outstanding
);
  // Queue machine states. Idle takes commands and data phase starts; the
  // enqueue state stores the slot and picks the answer frame; the release,
  // read setup, write setup and malformed states each hold one frame until
  // the transport reports it sent. Write path select spends one cycle so the
  // auto-activate choice is made from settled configuration inputs.
  typedef enum logic [2:0] {
    ST_DEVICE_IDLE,
    ST_ENQUEUE_COMMAND,
    ST_RELEASE_INTERFACE,
    ST_READ_DMA_SETUP,
    ST_WRITE_PATH_SELECT,
    ST_WRITE_SETUP_AUTO,
    ST_WRITE_SETUP_PLAIN,
    ST_MALFORMED_CMD_ERROR
  } qcel_state_t;

  // Whole state of the block except the u_skid buffer in one record, registered by one process.

  typedef struct packed {
    qcel_state_t fsm;
    logic halted;
    logic [SLOTS-1:0] outstanding;
    logic [4:0] slot;
    logic cur_write;
    logic malformed;
    qcel_pkg::qcel_err_img_t img;
    logic streaming;
    logic [8:0] idx;
    logic [7:0] sum;
    logic log_done;
    logic read_start;
    logic write_start;
    logic frame_valid;
    qcel_pkg::qcel_frame_t frame;
  } qcel_fsm_st_t;

  qcel_fsm_st_t st;
  qcel_fsm_st_t next_st;
  logic src_ready;
  logic [7:0] cur_byte;
  logic cmd_take;
  logic phase_take;
  logic log_start;

  // Builds a frame request; used by every sending state.
  function automatic qcel_pkg::qcel_frame_t mk_frame(
    input qcel_pkg::qcel_frame_kind_t kind, input logic [7:0] status,
    input logic [7:0] error, input logic irq, input logic [4:0] buf_id,
    input logic dir, input logic aa);
    qcel_pkg::qcel_frame_t f;
    f.kind = kind;
    f.status = status;
    f.error = error;
    f.irq = irq;
    f.buf_id = buf_id;
    f.dir_to_host = dir;
    f.auto_act = aa;
    return f;
  endfunction : mk_frame

  // Page byte for an index; reserved bytes read zero.
  function automatic logic [7:0] page_byte(input logic [8:0] i,
    input qcel_pkg::qcel_err_img_t m, input logic [7:0] vend);
    logic [7:0] b;
    b = 8'h00;
    if (i >= `QCEL_VENDOR_FIRST) begin
      b = vend;
    end else begin
      case (i[7:0])
        8'h00: b = {m.non_queued, 2'b00, m.slot};
        8'h02: b = m.status;
        8'h03: b = m.error;
        8'h04: b = m.sect_num;
        8'h05: b = m.cyl_low;
        8'h06: b = m.cyl_high;
        8'h07: b = m.dev_head;
        8'h08: b = m.sect_num_exp;
        8'h09: b = m.cyl_low_exp;
        8'h0a: b = m.cyl_high_exp;
        8'h0c: b = m.sect_cnt;
        8'h0d: b = m.sect_cnt_exp;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction : page_byte

  // Frame that lowers busy, data request and interrupt after an enqueue.
  function automatic qcel_pkg::qcel_frame_t release_frame();
    return mk_frame(qcel_pkg::QCEL_FR_REG, `QCEL_STAT_READY, 8'h00, 1'b0, 5'h00,
      1'b0, 1'b0);
  endfunction : release_frame

  // Frame for a malformed command: error bit and interrupt set, busy low.
  function automatic qcel_pkg::qcel_frame_t malformed_frame();
    return mk_frame(qcel_pkg::QCEL_FR_REG, `QCEL_STAT_READY | `QCEL_STAT_ERR,
      `QCEL_ABORT_ERR, 1'b1, 5'h00, 1'b0, 1'b0);
  endfunction : malformed_frame

  // Setup frame for a data phase; the buffer identifier is always the slot.
  function automatic qcel_pkg::qcel_frame_t setup_frame(input logic [4:0] slot,
    input logic to_host, input logic aa);
    return mk_frame(qcel_pkg::QCEL_FR_DMA_SETUP, 8'h00, 8'h00, 1'b0, slot,
      to_host, aa);
  endfunction : setup_frame

  // Log image for a malformed command: no valid slot, abort reported alone.
  // The error byte lives in the image, apart from the frame, so the value
  // sent when the failure was signalled never overwrites the logged one.
  function automatic qcel_pkg::qcel_err_img_t malformed_image();
    qcel_pkg::qcel_err_img_t m;
    m = '0;
    m.non_queued = 1'b1;
    m.status = `QCEL_STAT_READY | `QCEL_STAT_ERR;
    m.error = `QCEL_ABORT_ERR;
    return m;
  endfunction : malformed_image

  // Image reported from elsewhere; a non-queued failure carries no slot.
  function automatic qcel_pkg::qcel_err_img_t clean_image(
    input qcel_pkg::qcel_err_img_t m);
    qcel_pkg::qcel_err_img_t r;
    r = m;
    if (m.non_queued) begin
      r.slot = 5'h00;
    end
    return r;
  endfunction : clean_image

  // Sets one slot bit; an index past the configured depth is ignored.
  function automatic logic [SLOTS-1:0] mark_slot(input logic [SLOTS-1:0] q,
    input logic [4:0] s);
    logic [SLOTS-1:0] r;
    r = q;
    if (int'(s) < SLOTS) begin
      r[s] = 1'b1;
    end
    return r;
  endfunction : mark_slot

  // Reads one slot bit; an index past the configured depth reads as free.
  function automatic logic slot_set(input logic [SLOTS-1:0] q, input logic [4:0] s);
    logic r;
    r = 1'b0;
    if (int'(s) < SLOTS) begin
      r = q[s];
    end
    return r;
  endfunction : slot_set

  // Last byte carries the negated running sum.
  assign cur_byte = (st.idx == `QCEL_LOG_LAST) ? (8'h00 - st.sum) :
    page_byte(st.idx, st.img, vendor_byte);

  // The two-entry buffer lets the sink stall without losing a byte; the page
  // index only advances on a cycle in which the buffer takes the byte.
  qcel_skid #(
    .WIDTH(8)
  ) u_skid (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .in_valid(st.streaming),
    .in_data(cur_byte),
    .in_ready(src_ready),
    .out_valid(log_valid),
    .out_data(log_data),
    .out_ready(log_ready)
  );

  // Requests are taken only from a quiet idle; a halted machine takes neither.
  assign cmd_ready = (st.fsm == ST_DEVICE_IDLE) && !st.halted && !st.streaming;
  assign phase_ready = (st.fsm == ST_DEVICE_IDLE) && !st.halted && !st.streaming
    && !cmd_valid && slot_set(st.outstanding, phase_slot);
  assign cmd_take = cmd_valid && cmd_ready;
  assign phase_take = phase_valid && phase_ready;
  // A page read starts only from a quiet idle. It is refused in a cycle that
  // takes a command or phase, because the stream's end returns the machine to
  // idle and would otherwise cut that request's frame short.
  assign log_start = log_read && (log_page == `QCEL_LOG_PAGE) && !st.streaming
    && (st.fsm == ST_DEVICE_IDLE) && !cmd_take && !phase_take;
  // Every remaining output comes straight from the state record.
  assign frame_valid = st.frame_valid;
  assign frame = st.frame;
  assign log_done = st.log_done;
  assign halted = st.halted;
  assign read_data_start = st.read_start;
  assign write_data_start = st.write_start;
  assign outstanding = st.outstanding;

  // Next-state logic for the queue machine and the log streamer.
  always_comb begin
    next_st = st;
    next_st.log_done = 1'b0;
    next_st.read_start = 1'b0;
    next_st.write_start = 1'b0;
    case (st.fsm)
      // Idle: a command wins over a data phase start in the same cycle.
      ST_DEVICE_IDLE: begin
        if (cmd_take) begin
          next_st.slot = cmd.slot;
          next_st.cur_write = cmd.is_write;
          next_st.malformed = cmd.malformed;
          next_st.fsm = ST_ENQUEUE_COMMAND;
        end else if (phase_take) begin
          next_st.slot = phase_slot;
          if (phase_is_write) begin
            next_st.fsm = ST_WRITE_PATH_SELECT;
          end else begin
            next_st.frame_valid = 1'b1;
            next_st.frame = setup_frame(phase_slot, 1'b1, 1'b0);
            next_st.fsm = ST_READ_DMA_SETUP;
          end
        end
      end
      // Enqueue: store the slot, or refuse the command and halt.
      ST_ENQUEUE_COMMAND: begin
        next_st.frame_valid = 1'b1;
        if (st.malformed) begin
          next_st.halted = 1'b1;
          next_st.frame = malformed_frame();
          next_st.img = malformed_image();
          next_st.fsm = ST_MALFORMED_CMD_ERROR;
        end else begin
          next_st.outstanding = mark_slot(st.outstanding, st.slot);
          next_st.frame = release_frame();
          next_st.fsm = ST_RELEASE_INTERFACE;
        end
      end
      // Register frames drop back to idle once sent.
      ST_RELEASE_INTERFACE, ST_MALFORMED_CMD_ERROR: begin
        if (frame_done) begin
          next_st.frame_valid = 1'b0;
          next_st.fsm = ST_DEVICE_IDLE;
        end
      end
      // Read setup sent: the read data sender takes over.
      ST_READ_DMA_SETUP: begin
        if (frame_done) begin
          next_st.frame_valid = 1'b0;
          next_st.read_start = 1'b1;
          next_st.fsm = ST_DEVICE_IDLE;
        end
      end
      // Write path: the configuration is read here, one cycle after the take.
      ST_WRITE_PATH_SELECT: begin
        next_st.frame_valid = 1'b1;
        if (auto_act_supported && auto_act_enabled) begin
          next_st.frame = setup_frame(st.slot, 1'b0, 1'b1);
          next_st.fsm = ST_WRITE_SETUP_AUTO;
        end else begin
          next_st.frame = setup_frame(st.slot, 1'b0, 1'b0);
          next_st.fsm = ST_WRITE_SETUP_PLAIN;
        end
      end
      // Write setup sent: the write data receiver takes over.
      ST_WRITE_SETUP_AUTO, ST_WRITE_SETUP_PLAIN: begin
        if (frame_done) begin
          next_st.frame_valid = 1'b0;
          next_st.write_start = 1'b1;
          next_st.fsm = ST_DEVICE_IDLE;
        end
      end
      // Unused codes recover to idle.
      default: begin
        next_st.fsm = ST_DEVICE_IDLE;
      end
    endcase
    // A queued failure reported elsewhere halts the machine.
    if (err_valid) begin
      next_st.halted = 1'b1;
      next_st.img = clean_image(err_img);
    end
    // Log page read starts the stream from byte zero.
    if (log_start) begin
      next_st.streaming = 1'b1;
      next_st.idx = 9'h000;
      next_st.sum = 8'h00;
    end else if (st.streaming && src_ready) begin
      next_st.sum = st.sum + cur_byte;
      next_st.idx = st.idx + 9'h001;
      if (st.idx == `QCEL_LOG_LAST) begin
        next_st.streaming = 1'b0;
        next_st.log_done = 1'b1;
        next_st.outstanding = '0;
        next_st.halted = err_valid;
        next_st.fsm = ST_DEVICE_IDLE;
      end
    end
  end

  // The clock enable freezes all state.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule : qcel_queue_fsm

/* File: rtl/qcel_skid.sv */
// Purpose: Two-entry buffer for the log byte stream.
// Assumes: Source honours in_ready.
// Notes: Full throughput; a sink stall loses no word.
`timescale 1ns/10ps
module qcel_skid #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clk_en,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic [1:0] cnt;
  } qcel_skid_st_t;

  qcel_skid_st_t st;
  qcel_skid_st_t next_st;

  assign in_ready = (st.cnt != 2'd2);
  assign out_valid = (st.cnt != 2'd0);
  assign out_data = st.mem[st.rd];

  // Push writes behind the read slot; pop advances the read index.
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    next_st = st;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      next_st.mem[st.rd ^ st.cnt[0]] = in_data;
    end
    if (pop) begin
      next_st.rd = ~st.rd;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  // The clock enable freezes the buffer.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else if (clk_en) begin
      st <= next_st;
    end
  end
endmodule : qcel_skid
